// ### rsi_pkg.sv
// constants and types of the reset state initializer
package rsi_pkg;
    //--------------------------------------------------------------
    // register map, byte addresses on the bus
    //--------------------------------------------------------------
    localparam int RSI_AW = 4;
    localparam logic [3:0] RSI_ADR_STATUS = 4'h0;
    localparam logic [3:0] RSI_ADR_RESET_FUNCTION_CONTROL = 4'h4;
    localparam logic [3:0] RSI_ADR_IRQ_STAT = 4'h8;
    localparam logic [3:0] RSI_ADR_IRQ_MASK = 4'hC;
    localparam logic [31:0] RSI_RD_ZERO = 32'h0000_0000;

    //--------------------------------------------------------------
    // status register layout
    //--------------------------------------------------------------
    localparam int RSI_ST_TO = 0;
    localparam int RSI_ST_PDF = 1;
    localparam int RSI_ST_CAUSE = 2;
    localparam int RSI_ST_MODE = 6;

    //--------------------------------------------------------------
    // reset values
    //--------------------------------------------------------------
    localparam logic [7:0] RSI_RESET_FUNCTION_CONTROL_POR = 8'h55;
    localparam logic [7:0] RSI_V_ZERO = 8'h00;
    localparam logic [7:0] RSI_V_ONES = 8'hFF;
    localparam logic [7:0] RSI_V_WDTC = 8'h53;
    localparam logic [7:0] RSI_V_LVRC = 8'h66;
    localparam logic [7:0] RSI_V_PCRH = 8'h7F;
    localparam logic [5:0] RSI_IRQ_NONE = 6'h00;

    //--------------------------------------------------------------
    // reset causes, one-hot
    //--------------------------------------------------------------
    localparam logic [3:0] RSI_C_POR = 4'h1;
    localparam logic [3:0] RSI_C_PIN = 4'h2;
    localparam logic [3:0] RSI_C_LVR = 4'h4;
    localparam logic [3:0] RSI_C_WDT = 4'h8;

    //--------------------------------------------------------------
    // operating modes as reported by the core
    //--------------------------------------------------------------
    localparam logic [1:0] RSI_M_FAST = 2'h0;
    localparam logic [1:0] RSI_M_SLOW = 2'h1;
    localparam logic [1:0] RSI_M_IDLE = 2'h2;
    localparam logic [1:0] RSI_M_SLEEP = 2'h3;

    //--------------------------------------------------------------
    // interrupt status bits
    //--------------------------------------------------------------
    localparam int RSI_I_POR = 0;
    localparam int RSI_I_PIN = 1;
    localparam int RSI_I_LVR = 2;
    localparam int RSI_I_WDT = 3;
    localparam int RSI_I_WARM = 4;
    localparam int RSI_I_DONE = 5;
    localparam int RSI_IRQ_W = 6;

    //--------------------------------------------------------------
    // initial-value table slots
    //--------------------------------------------------------------
    localparam int RSI_TBL_N = 8;
    localparam int RSI_TBL_AW = 3;
    localparam logic [2:0] RSI_T_PCL = 3'h0;
    localparam logic [2:0] RSI_T_INTC = 3'h1;
    localparam logic [2:0] RSI_T_PORT = 3'h2;
    localparam logic [2:0] RSI_T_DIR = 3'h3;
    localparam logic [2:0] RSI_T_PULL = 3'h4;
    localparam logic [2:0] RSI_T_WDTC = 3'h5;
    localparam logic [2:0] RSI_T_LVRC = 3'h6;
    localparam logic [2:0] RSI_T_PCRH = 3'h7;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        RSI_S_IDLE = 4'b0001,
        RSI_S_APPLY = 4'b0010,
        RSI_S_WALK = 4'b0100,
        RSI_S_DONE = 4'b1000
    } rsi_state_t;
endpackage

// ### rsi_init_rom.sv
// table of initial values loaded into core registers after reset
`timescale 1ns/1ps
`default_nettype none
module rsi_init_rom
    import rsi_pkg::*;
#(
    parameter int AW = RSI_TBL_AW
)(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // read port
    input wire logic [AW-1:0] i_addr,
    output logic [7:0] o_value,
    output logic o_keep
);
    //--------------------------------------------------------------
    // table contents
    //--------------------------------------------------------------
    logic [7:0] value_w; // value for the slot
    logic keep_w; // slot kept on a warm watchdog reset

    always_comb
    begin
        value_w = RSI_V_ZERO;
        keep_w = 1'b1;
        case (i_addr)
            RSI_T_PCL: keep_w = 1'b0; // always cleared
            RSI_T_INTC: value_w = RSI_V_ZERO;
            RSI_T_PORT: value_w = RSI_V_ONES;
            RSI_T_DIR: value_w = RSI_V_ONES; // all inputs
            RSI_T_PULL: value_w = RSI_V_ZERO;
            RSI_T_WDTC: value_w = RSI_V_WDTC;
            RSI_T_LVRC: value_w = RSI_V_LVRC;
            RSI_T_PCRH: value_w = RSI_V_PCRH;
            default: value_w = RSI_V_ZERO;
        endcase
    end

    // read data comes out of a register
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_value <= RSI_V_ZERO;
            o_keep <= 1'b0;
        end
        else
        begin
            o_value <= value_w;
            o_keep <= keep_w;
        end
    end
endmodule
`default_nettype wire

// ### rsi_top.sv
// reset state initializer: flags, init pulses and register value walk
// What this block does
// - warm watchdog expiry sets timeout and powerdown
// - normal watchdog expiry sets timeout, keeps powerdown
// - pin or low-voltage reset keeps both flags
// - power-on reset clears both flags
// - flags held here, updated on sleep and watchdog
// - power-on reset zeroes the program counter
// - reset other than warm watchdog disables all interrupt sources
// - reset clears watchdog and time bases, watchdog runs
// - reset other than warm watchdog switches off all timers
// - reset other than warm watchdog makes every port pin an input
// - reset other than warm watchdog points stack pointer at stack top
// - register values chosen by reset type
// - control register restored except warm watchdog
// - warm watchdog zeroes program counter and stack
`timescale 1ns/1ps
`default_nettype none
module rsi_top
    import rsi_pkg::*;
#(
    parameter int TBL_N = RSI_TBL_N
)(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // reset sources, one-cycle pulses
    input wire logic i_por,
    input wire logic i_external_reset_pin,
    input wire logic i_low_voltage_reset,
    input wire logic i_wdt_expire,
    // core state
    input wire logic [1:0] i_mode,
    input wire logic i_sleep_entry,
    input wire logic i_wdt_clear_instr,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [RSI_AW-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // initialisation outputs
    output logic o_core_hold,
    output logic o_pc_clear,
    output logic o_sp_top,
    output logic o_sp_zero,
    output logic o_int_disable,
    output logic o_wdt_clear,
    output logic o_timer_off,
    output logic o_io_input,
    output logic o_init_we,
    output logic [RSI_TBL_AW-1:0] o_init_idx,
    output logic [7:0] o_init_data,
    // flags and control
    output logic o_timeout_flag,
    output logic o_powerdown_flag,
    output logic [7:0] o_reset_function_control,
    output logic o_irq
);
    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    // idle or sleep counts as low power
    function automatic logic low_pwr(input logic [1:0] m);
        low_pwr = (m == RSI_M_IDLE) || (m == RSI_M_SLEEP);
    endfunction

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    rsi_state_t state_q, state_d; // sequencer state
    logic [3:0] cause_q; // recorded reset cause
    logic [1:0] mode_q; // mode at reset
    logic [RSI_TBL_AW-1:0] idx_q; // table walk index
    logic [RSI_TBL_AW-1:0] idx_p_q; // index of rom output
    logic walk_v_q; // rom output valid
    logic [7:0] rom_value; // table value
    logic rom_keep; // table keep-on-warm bit
    logic [5:0] irq_stat_q, irq_mask_q; // interrupt regs
    logic wb_ack_q; // bus answer

    //--------------------------------------------------------------
    // decode
    //--------------------------------------------------------------
    wire ev_any = i_por | i_external_reset_pin | i_low_voltage_reset
        | i_wdt_expire;
    wire [3:0] cause_d = i_por ? RSI_C_POR
        : i_external_reset_pin ? RSI_C_PIN
        : i_low_voltage_reset ? RSI_C_LVR : RSI_C_WDT;
    wire in_apply = (state_q == RSI_S_APPLY);
    wire is_wdt = (cause_q == RSI_C_WDT);
    wire warm = is_wdt && low_pwr(mode_q);
    wire walk_last = (idx_q == RSI_TBL_AW'(TBL_N - 1));
    wire bus_req = i_wb_cyc & i_wb_stb & ~wb_ack_q;
    wire bus_wr = bus_req & i_wb_we & i_wb_sel[0];
    wire wr_reset_function_control = bus_wr && (i_wb_adr == RSI_ADR_RESET_FUNCTION_CONTROL);
    wire wr_stat = bus_wr && (i_wb_adr == RSI_ADR_IRQ_STAT);
    wire wr_mask = bus_wr && (i_wb_adr == RSI_ADR_IRQ_MASK);
    wire [7:0] status_w = {mode_q, cause_q, o_powerdown_flag,
        o_timeout_flag};
    wire [5:0] irq_set = {state_q == RSI_S_DONE,
        in_apply & warm, in_apply & is_wdt & ~warm,
        in_apply & (cause_q == RSI_C_LVR),
        in_apply & (cause_q == RSI_C_PIN),
        in_apply & (cause_q == RSI_C_POR)};
    // set wins over a write-one clear in the same cycle
    wire [5:0] irq_stat_d = (irq_stat_q & ~({6{wr_stat}}
        & i_wb_dat[5:0])) | irq_set;
    wire [31:0] rd_w = (i_wb_adr == RSI_ADR_STATUS) ? {24'h0, status_w}
        : (i_wb_adr == RSI_ADR_RESET_FUNCTION_CONTROL) ? {24'h0, o_reset_function_control}
        : (i_wb_adr == RSI_ADR_IRQ_STAT) ? {26'h0, irq_stat_q}
        : (i_wb_adr == RSI_ADR_IRQ_MASK) ? {26'h0, irq_mask_q}
        : RSI_RD_ZERO;

    //--------------------------------------------------------------
    // initial-value table
    //--------------------------------------------------------------
    rsi_init_rom #(.AW(RSI_TBL_AW)) u_rom (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_addr(idx_q),
        .o_value(rom_value),
        .o_keep(rom_keep)
    );

    //--------------------------------------------------------------
    // sequencer next state
    //--------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RSI_S_IDLE: state_d = RSI_S_IDLE;
            RSI_S_APPLY: state_d = RSI_S_WALK;
            RSI_S_WALK: state_d = walk_last ? RSI_S_DONE : RSI_S_WALK;
            RSI_S_DONE: state_d = RSI_S_IDLE;
            default: state_d = RSI_S_IDLE;
        endcase
        // a new reset source restarts the sequence
        if (ev_any)
            state_d = RSI_S_APPLY;
    end

    // state, cause and mode capture
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= RSI_S_IDLE;
            cause_q <= RSI_C_POR;
            mode_q <= RSI_M_FAST;
        end
        else
        begin
            state_q <= state_d;
            if (ev_any)
            begin
                cause_q <= cause_d;
                mode_q <= i_mode;
            end
        end
    end

    // table walk index and rom pipeline
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            idx_q <= RSI_T_PCL;
            idx_p_q <= RSI_T_PCL;
            walk_v_q <= 1'b0;
        end
        else
        begin
            idx_q <= (state_q == RSI_S_WALK && !walk_last)
                ? idx_q + 1'b1 : RSI_T_PCL;
            idx_p_q <= idx_q;
            walk_v_q <= (state_q == RSI_S_WALK) && !ev_any;
        end
    end

    // register loads; warm watchdog keeps the preserved slots
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_init_we <= 1'b0;
            o_init_idx <= RSI_T_PCL;
            o_init_data <= RSI_V_ZERO;
        end
        else
        begin
            o_init_we <= walk_v_q && !(warm && rom_keep);
            o_init_idx <= idx_p_q;
            o_init_data <= rom_value;
        end
    end

    // core and peripheral pulses
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_core_hold <= 1'b1;
            o_pc_clear <= 1'b0;
            o_sp_top <= 1'b0;
            o_sp_zero <= 1'b0;
            o_int_disable <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_timer_off <= 1'b0;
            o_io_input <= 1'b0;
        end
        else
        begin
            o_core_hold <= (state_d != RSI_S_IDLE);
            o_pc_clear <= in_apply;
            o_sp_top <= in_apply & ~warm;
            o_sp_zero <= in_apply & warm;
            o_int_disable <= in_apply & ~warm;
            o_wdt_clear <= in_apply;
            o_timer_off <= in_apply & ~warm;
            o_io_input <= in_apply & ~warm;
        end
    end

    // timeout and powerdown flags
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_timeout_flag <= 1'b0;
            o_powerdown_flag <= 1'b0;
        end
        else if (in_apply)
        begin
            if (cause_q == RSI_C_POR)
            begin
                o_timeout_flag <= 1'b0;
                o_powerdown_flag <= 1'b0;
            end
            else if (is_wdt)
            begin
                o_timeout_flag <= 1'b1;
                if (warm)
                    o_powerdown_flag <= 1'b1;
            end
            // pin or low-voltage: unchanged
        end
        else if (state_q == RSI_S_IDLE && i_wdt_clear_instr)
        begin
            o_timeout_flag <= 1'b0;
            o_powerdown_flag <= 1'b0;
        end
        else if (state_q == RSI_S_IDLE && i_sleep_entry)
        begin
            o_timeout_flag <= 1'b0;
            o_powerdown_flag <= 1'b1;
        end
    end

    // reset function control register
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_reset_function_control <= RSI_RESET_FUNCTION_CONTROL_POR;
        else if (in_apply && !warm)
            o_reset_function_control <= RSI_RESET_FUNCTION_CONTROL_POR;
        else if (wr_reset_function_control)
            o_reset_function_control <= i_wb_dat[7:0];
    end

    // interrupt registers and output
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_stat_q <= RSI_IRQ_NONE;
            irq_mask_q <= RSI_IRQ_NONE;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask)
                irq_mask_q <= i_wb_dat[5:0];
            o_irq <= |(irq_stat_d & (wr_mask ? i_wb_dat[5:0]
                : irq_mask_q));
        end
    end

    // bus answer, one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wb_ack_q <= 1'b0;
            o_wb_dat <= RSI_RD_ZERO;
        end
        else
        begin
            wb_ack_q <= bus_req;
            o_wb_dat <= bus_req ? rd_w : RSI_RD_ZERO;
        end
    end
    assign o_wb_ack = wb_ack_q;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    property p_warm_flags;
        in_apply && warm |=> o_timeout_flag && o_powerdown_flag;
    endproperty
    a_warm_flags: assert property (p_warm_flags)
        else $error("warm watchdog flags wrong");

    property p_norm_wdt;
        in_apply && is_wdt && !warm |=> o_timeout_flag
            && (o_powerdown_flag == $past(o_powerdown_flag));
    endproperty
    a_norm_wdt: assert property (p_norm_wdt)
        else $error("normal watchdog flags wrong");

    property p_pin_keep;
        in_apply && (cause_q == RSI_C_PIN || cause_q == RSI_C_LVR)
            |=> $stable(o_timeout_flag) && $stable(o_powerdown_flag);
    endproperty
    a_pin_keep: assert property (p_pin_keep)
        else $error("pin reset changed flags");

    property p_por_clear;
        in_apply && cause_q == RSI_C_POR
            |=> !o_timeout_flag && !o_powerdown_flag;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("power-on did not clear flags");

    property p_sleep;
        state_q == RSI_S_IDLE && i_sleep_entry && !i_wdt_clear_instr
            |=> o_powerdown_flag && !o_timeout_flag;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry flags wrong");

    property p_init_pulses;
        in_apply && !warm |=> o_pc_clear && o_sp_top && o_int_disable
            && o_timer_off && o_io_input ##1 !o_int_disable;
    endproperty
    a_init_pulses: assert property (p_init_pulses)
        else $error("reset pulses missing");

    property p_wdt_run;
        in_apply |=> o_wdt_clear ##1 !o_wdt_clear;
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("watchdog clear not a pulse");

    property p_warm_core;
        in_apply && warm |=> o_pc_clear && o_sp_zero && !o_sp_top
            && !o_int_disable;
    endproperty
    a_warm_core: assert property (p_warm_core)
        else $error("warm reset core pulses wrong");

    property p_reset_function_control;
        in_apply && !warm |=> o_reset_function_control == RSI_RESET_FUNCTION_CONTROL_POR;
    endproperty
    a_reset_function_control: assert property (p_reset_function_control)
        else $error("control register not restored");

    property p_warm_keep;
        walk_v_q && warm && rom_keep |=> !o_init_we;
    endproperty
    a_warm_keep: assert property (p_warm_keep)
        else $error("preserved register loaded");

    property p_cause;
        ev_any |=> cause_q == $past(cause_d) && mode_q == $past(i_mode);
    endproperty
    a_cause: assert property (p_cause)
        else $error("reset cause not recorded");

    c_warm: cover property (in_apply && warm ##[1:20] state_q == RSI_S_DONE);
    c_por: cover property (in_apply && cause_q == RSI_C_POR ##1 o_pc_clear);
    c_irq: cover property ($rose(o_irq));
endmodule
`default_nettype wire

// ### rsi_core_model.sv
// behavioural model of the core registers loaded after a reset
`timescale 1ns/1ps
`default_nettype none
module rsi_core_model
    import rsi_pkg::*;
(
    // clock and clear of the pulse record
    input wire logic i_clk_sys,
    input wire logic i_clr,
    // strobes from the block
    input wire logic [6:0] i_pulse,
    input wire logic i_init_we,
    input wire logic [RSI_TBL_AW-1:0] i_init_idx,
    input wire logic [7:0] i_init_data,
    // observed state
    output logic [6:0] o_seen,
    output logic [RSI_TBL_N-1:0][7:0] o_tbl
);
    //----------------------------------------------------------
    // record of init pulses and loaded register values
    //----------------------------------------------------------
    // pulses are or-ed so a missing or stray one shows up
    always @(posedge i_clk_sys)
    begin
        if (i_clr)
            o_seen <= 7'h00;
        else
            o_seen <= o_seen | i_pulse;
        if (i_init_we)
            o_tbl[i_init_idx] <= i_init_data;
    end
endmodule
`default_nettype wire

// ### reset_state_initializer_tb.sv
// self-checking bench of the reset state initializer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module reset_state_initializer_tb;
    import rsi_pkg::*;
    //----------------------------------------------------------
    // stimulus and observed signals
    //----------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic por = 1'b0, pin = 1'b0, low_voltage_reset = 1'b0, wdt = 1'b0;
    logic slp = 1'b0, wclr = 1'b0, clr = 1'b0;
    logic [1:0] mode = 2'h0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, hold, pcc, spt, spz, intd, wdc, tmo, ioi, iwe, tof, powerdown_flag, irq;
    logic [2:0] idx;
    logic [7:0] idat, ctl;
    logic [6:0] seen;
    logic [RSI_TBL_N-1:0][7:0] tbl;
    logic [1:0] exp_fl; // expected {timeout, powerdown}
    logic [7:0] exp_tbl [8];
    logic [7:0] exp_ctl; // expected control register after a reset
    int fails = 0, comparisons = 0, cyc_n = 0, n_we = 0;

    //----------------------------------------------------------
    // clock, timeout, design and core model
    //----------------------------------------------------------
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        cyc_n++;
        if (cyc_n == 5000)
        begin
            fails++;
            give_verdict();
        end
    end
    // init-write beats seen on the table port
    always @(posedge i_clk_sys)
    begin
        if (iwe)
            n_we++;
    end
    rsi_top dut_u (.i_clk_sys, .i_rstn, .i_por(por),
        .i_external_reset_pin(pin), .i_low_voltage_reset(low_voltage_reset),
        .i_wdt_expire(wdt), .i_mode(mode), .i_sleep_entry(slp),
        .i_wdt_clear_instr(wclr), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_core_hold(hold),
        .o_pc_clear(pcc), .o_sp_top(spt), .o_sp_zero(spz),
        .o_int_disable(intd), .o_wdt_clear(wdc), .o_timer_off(tmo),
        .o_io_input(ioi), .o_init_we(iwe), .o_init_idx(idx),
        .o_init_data(idat), .o_timeout_flag(tof), .o_powerdown_flag(powerdown_flag),
        .o_reset_function_control(ctl), .o_irq(irq));
    rsi_core_model core_u (.i_clk_sys, .i_clr(clr),
        .i_pulse({ioi, tmo, wdc, intd, spz, spt, pcc}), .i_init_we(iwe),
        .i_init_idx(idx), .i_init_data(idat), .o_seen(seen), .o_tbl(tbl));

    //----------------------------------------------------------
    // expectation functions and bus tasks
    //----------------------------------------------------------
    // power-on value of each table slot
    function automatic logic [7:0] dflt(input int i);
        case (i)
            2, 3: return RSI_V_ONES;
            5: return RSI_V_WDTC;
            6: return RSI_V_LVRC;
            7: return RSI_V_PCRH;
            default: return RSI_V_ZERO;
        endcase
    endfunction
    // flags after a reset of cause k
    function automatic logic [1:0] flags(input int k, input logic warm,
        input logic [1:0] old);
        if (k == 0)
            return 2'b00;
        if (warm)
            return 2'b11;
        if (k == 3)
            return {1'b1, old[0]};
        return old;
    endfunction
    // one classic cycle, waits for ack
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
        int n;
        @(posedge i_clk_sys);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        n = 0;
        @(posedge i_clk_sys);
        while (ack !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge i_clk_sys);
        end
        r = rdat;
        `CHK(ack, 1'b1)
        {cyc, stb, we} <= 3'b000;
    endtask
    // one reset event of cause k in mode m, then checks
    task automatic fire(input int k, input logic [1:0] m);
        logic warm;
        logic [7:0] ctl0;
        logic [5:0] msk, st;
        logic [1:0] s;
        int w0;
        warm = (k == 3) && m[1];
        ctl0 = 8'($urandom);
        msk = 6'($urandom);
        s = 2'($urandom);
        wb(1'b1, RSI_ADR_RESET_FUNCTION_CONTROL, {24'h0, ctl0}, 4'h1, rd);
        wb(1'b1, RSI_ADR_IRQ_STAT, 32'h3F, 4'hF, rd);
        wb(1'b1, RSI_ADR_IRQ_MASK, {26'h0, msk}, 4'h1, rd);
        // sleep entry and clear instruction before the event
        @(posedge i_clk_sys);
        {slp, wclr} <= s;
        @(posedge i_clk_sys);
        {slp, wclr} <= 2'b00;
        // s is {sleep, clear}; the clear instruction wins over sleep
        exp_fl = s[0] ? 2'b00 : (s[1] ? 2'b01 : exp_fl);
        repeat (2) @(posedge i_clk_sys);
        `CHK({tof, powerdown_flag}, exp_fl)
        w0 = n_we;
        {clr, mode} <= {1'b1, m};
        {wdt, low_voltage_reset, pin, por} <= 4'h1 << k;
        @(posedge i_clk_sys);
        {clr, wdt, low_voltage_reset, pin, por} <= 5'h00;
        repeat (14) @(posedge i_clk_sys);
        exp_fl = flags(k, warm, exp_fl);
        `CHK({tof, powerdown_flag}, exp_fl)
        `CHK(seen, warm ? 7'h15 : 7'h7B)
        exp_ctl = warm ? ctl0 : RSI_RESET_FUNCTION_CONTROL_POR;
        `CHK(ctl, exp_ctl)
        `CHK(n_we - w0, warm ? 1 : 8)
        `CHK(hold, 1'b0)
        for (int i = 0; i < 8; i++)
        begin
            if (!warm || i == 0)
                exp_tbl[i] = dflt(i);
            `CHK(tbl[i], exp_tbl[i])
        end
        wb(1'b0, RSI_ADR_STATUS, 32'h0, 4'h0, rd);
        `CHK(rd, {24'h0, m, 4'h1 << k, exp_fl[0], exp_fl[1]})
        st = (6'h1 << (warm ? 4 : k)) | 6'h20;
        wb(1'b0, RSI_ADR_IRQ_STAT, 32'h0, 4'h0, rd);
        `CHK(rd, {26'h0, st})
        `CHK(irq, |(st & msk))
    endtask

    //----------------------------------------------------------
    // verdict
    //----------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    //----------------------------------------------------------
    // main sequence
    //----------------------------------------------------------
    initial
    begin
        void'($urandom(32'hCB0E3219));
        exp_fl = 2'b00;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        // values right after reset
        wb(1'b0, RSI_ADR_RESET_FUNCTION_CONTROL, 32'h0, 4'h0, rd);
        `CHK(rd, {24'h0, RSI_RESET_FUNCTION_CONTROL_POR})
        wb(1'b0, RSI_ADR_IRQ_MASK, 32'h0, 4'h0, rd);
        `CHK(rd, RSI_RD_ZERO)
        `CHK({tof, powerdown_flag, irq}, 3'b000)
        // every cause in every mode, then random ones
        fire(0, RSI_M_FAST);
        for (int k = 0; k < 4; k++)
            for (int m = 0; m < 4; m++)
                fire(k, 2'(m));
        repeat (16) fire($urandom_range(0, 3), 2'($urandom));
        // write without byte lane 0 is ignored, unmapped reads zero
        wb(1'b1, RSI_ADR_RESET_FUNCTION_CONTROL, 32'hAA, 4'hE, rd);
        wb(1'b0, RSI_ADR_RESET_FUNCTION_CONTROL, 32'h0, 4'h0, rd);
        `CHK(rd, {24'h0, exp_ctl})
        wb(1'b0, 4'h2, 32'h0, 4'h0, rd);
        `CHK(rd, RSI_RD_ZERO)
        give_verdict();
    end
endmodule
`default_nettype wire
